// >>> src/lcsd_decoder.sv
// Local chip select decoder with APB register access.
`timescale 1ns/1ps

module lcsd_decoder #(
    parameter int unsigned LADDR_W = lcsd_pkg::WIN_W
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [lcsd_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Local bus cycle
    input  wire logic [LADDR_W-1:0]          local_addr,
    input  wire logic                        local_addr_strobe,
    input  wire logic                        local_cycle_active,
    input  wire logic                        local_space_claimed,
    // Dedicated selects
    output logic                             device_select0_n,
    output logic                             device_select1_n,
    // Shared pin two
    input  wire logic                        user_io_two_i,
    output logic                             user_io_two_o,
    output logic                             user_io_two_oe,
    // Shared pin three
    input  wire logic                        user_io_three_i,
    output logic                             user_io_three_o,
    output logic                             user_io_three_oe
);

    localparam int unsigned NW = lcsd_pkg::NUM_WIN;
    localparam int unsigned WW = lcsd_pkg::WIN_W;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (LADDR_W != WW)
    begin : g_bad_width
        $error("Local address width must equal the window register width.");
    end

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic [WW-1:0]                   window_reg [NW];
    logic [NW-1:0]                   win_addr_hit;
    logic [NW-1:0]                   match_now;
    logic [NW-1:0]                   hit_reg;
    logic [NW-1:0]                   select_n_reg;
    logic [NW-1:0]                   select_n_next;
    logic [lcsd_pkg::IOCTL_W-1:0]    ioctl_reg;
    logic [31:0]                     prdata_reg;
    logic [31:0]                     rdata_next;
    logic                            setup_phase;
    logic                            access_phase;
    logic                            write_taken;
    logic                            addr_mapped;
    logic                            ioctl_hit;
    logic                            status_hit;
    logic [lcsd_pkg::NUM_SHARED-1:0] user_in;
    logic [lcsd_pkg::NUM_SHARED-1:0] shared_o;
    logic [lcsd_pkg::NUM_SHARED-1:0] shared_oe;

    // ----------------------------------------------------------------
    // APB phase decode
    // ----------------------------------------------------------------
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign write_taken  = access_phase && pwrite && addr_mapped;
    assign ioctl_hit    = (paddr == lcsd_pkg::OFS_IOCTL);
    assign status_hit   = (paddr == lcsd_pkg::OFS_STATUS);
    assign addr_mapped  = (|win_addr_hit) || ioctl_hit || status_hit;
    assign pready       = 1'b1;
    assign pslverr      = access_phase && !addr_mapped;
    assign prdata       = prdata_reg;

    // ----------------------------------------------------------------
    // Windows and their comparators
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NW; i++)
    begin : g_win
        assign win_addr_hit[i] = (paddr == 8'(lcsd_pkg::OFS_WIN0 + i * lcsd_pkg::WIN_STRIDE));

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                window_reg[i] <= lcsd_pkg::WIN_RESET;
            end
            else if (write_taken && win_addr_hit[i])
            begin
                window_reg[i] <= pwdata[WW-1:0];
            end
        end

        lcsd_window_match #(
            .WIDTH  (WW)
        ) u_match (
            .window (window_reg[i]),
            .addr   (local_addr),
            .hit    (match_now[i])
        );
    end

    // ----------------------------------------------------------------
    // User pin control register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ioctl_reg <= lcsd_pkg::IOCTL_RESET;
        end
        else if (write_taken && ioctl_hit)
        begin
            ioctl_reg <= pwdata[lcsd_pkg::IOCTL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Local cycle tracking and select generation
    // ----------------------------------------------------------------
    always_comb
    begin
        if (local_addr_strobe && local_space_claimed)
        begin
            select_n_next = ~match_now;
        end
        else if (local_addr_strobe)
        begin
            select_n_next = '1;
        end
        else if (!local_cycle_active)
        begin
            select_n_next = '1;
        end
        else
        begin
            select_n_next = select_n_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            select_n_reg <= '1;
        end
        else
        begin
            select_n_reg <= select_n_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hit_reg <= '0;
        end
        else if (local_addr_strobe)
        begin
            hit_reg <= match_now & {NW{local_space_claimed}};
        end
    end

    assign device_select0_n = select_n_reg[0];
    assign device_select1_n = select_n_reg[1];

    // ----------------------------------------------------------------
    // Shared pins
    // ----------------------------------------------------------------
    assign user_in = {user_io_three_i, user_io_two_i};

    for (genvar p = 0; p < lcsd_pkg::NUM_SHARED; p++)
    begin : g_pin
        lcsd_user_pin u_pin (
            .pclk       (pclk),
            .presetn    (presetn),
            .use_select (ioctl_reg[lcsd_pkg::IOCTL_SEL + p]),
            .user_oe    (ioctl_reg[lcsd_pkg::IOCTL_OE + p]),
            .user_out   (ioctl_reg[lcsd_pkg::IOCTL_OUT + p]),
            .select_n   (select_n_next[lcsd_pkg::FIRST_SHARED + p]),
            .pin_o      (shared_o[p]),
            .pin_oe     (shared_oe[p])
        );
    end

    assign user_io_two_o    = shared_o[0];
    assign user_io_two_oe   = shared_oe[0];
    assign user_io_three_o  = shared_o[1];
    assign user_io_three_oe = shared_oe[1];

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_next = 32'h00000000;
        for (int k = 0; k < NW; k++)
        begin
            if (win_addr_hit[k])
            begin
                rdata_next[WW-1:0] = window_reg[k];
            end
        end
        if (ioctl_hit)
        begin
            rdata_next[lcsd_pkg::IOCTL_W-1:0] = ioctl_reg;
        end
        if (status_hit)
        begin
            rdata_next[lcsd_pkg::ST_SEL_N +: NW]                 = select_n_reg;
            rdata_next[lcsd_pkg::ST_UIN +: lcsd_pkg::NUM_SHARED] = user_in;
            rdata_next[lcsd_pkg::ST_CYCLE]                       = local_cycle_active;
            rdata_next[lcsd_pkg::ST_HIT +: NW]                   = hit_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h00000000;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata_reg <= rdata_next;
        end
    end

endmodule : lcsd_decoder

// >>> common/lcsd_pkg.sv
// Shared constants for the local chip select decoder.
package lcsd_pkg;

    // ----------------------------------------------------------------
    // Window geometry
    // ----------------------------------------------------------------
    localparam int unsigned WIN_W      = 28;
    localparam int unsigned NUM_WIN    = 4;
    localparam int unsigned ENABLE_BIT = 0;
    localparam int unsigned RANGE_LSB  = 1;
    localparam logic [27:0] WIN_RESET  = 28'h0000000;

    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam int unsigned APB_AW     = 8;
    localparam logic [7:0]  OFS_WIN0   = 8'h00;
    localparam logic [7:0]  WIN_STRIDE = 8'h04;
    localparam logic [7:0]  OFS_IOCTL  = 8'h10;
    localparam logic [7:0]  OFS_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // User pin control fields
    // ----------------------------------------------------------------
    localparam int unsigned NUM_SHARED   = 2;
    localparam int unsigned FIRST_SHARED = 2;
    localparam int unsigned IOCTL_W      = 6;
    localparam int unsigned IOCTL_SEL    = 0;
    localparam int unsigned IOCTL_OE     = 2;
    localparam int unsigned IOCTL_OUT    = 4;
    localparam logic [5:0]  IOCTL_RESET  = 6'h00;

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int unsigned ST_SEL_N  = 0;
    localparam int unsigned ST_UIN    = 4;
    localparam int unsigned ST_CYCLE  = 6;
    localparam int unsigned ST_HIT    = 8;

endpackage : lcsd_pkg

// >>> src/lcsd_window_match.sv
// Address comparison for one select window.
`timescale 1ns/1ps

module lcsd_window_match #(
    parameter int unsigned WIDTH = 28
) (
    // Window and address
    input  wire logic [WIDTH-1:0] window,
    input  wire logic [WIDTH-1:0] addr,
    // Result
    output logic                  hit
);

    logic [WIDTH-1:0] range_field;
    logic [WIDTH-1:0] range_bit;
    logic [WIDTH-1:0] base_mask;

    // ----------------------------------------------------------------
    // Match
    // ----------------------------------------------------------------
    always_comb
    begin
        range_field = window & ~(WIDTH'(1) << lcsd_pkg::ENABLE_BIT);
        range_bit   = range_field & (~range_field + WIDTH'(1));
        base_mask   = ~(range_bit | (range_bit - WIDTH'(1)));
        hit         = window[lcsd_pkg::ENABLE_BIT]
                      && (((addr ^ window) & base_mask) == '0);
    end

endmodule : lcsd_window_match

// >>> src/lcsd_user_pin.sv
// One pin shared between a select output and a user I/O.
`timescale 1ns/1ps

module lcsd_user_pin (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Configuration
    input  wire logic use_select,
    input  wire logic user_oe,
    input  wire logic user_out,
    // Select source
    input  wire logic select_n,
    // Pin
    output logic      pin_o,
    output logic      pin_oe
);

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o  <= 1'b1;
            pin_oe <= 1'b0;
        end
        else if (use_select)
        begin
            pin_o  <= select_n;
            pin_oe <= 1'b1;
        end
        else
        begin
            pin_o  <= user_out;
            pin_oe <= user_oe;
        end
    end

endmodule : lcsd_user_pin

// >>> tb/lcsd_local_dev.sv
// Local bus peripheral model that resolves the shared user pins.
`timescale 1ns/1ps
module lcsd_local_dev (
    // Pins from the decoder
    input  wire logic two_o,
    input  wire logic two_oe,
    input  wire logic three_o,
    input  wire logic three_oe,
    // Levels seen on the wires
    output logic      two_i,
    output logic      three_i
);
    // Undriven pins are pulled low by the board.
    assign two_i   = two_oe ? two_o : 1'b0;
    assign three_i = three_oe ? three_o : 1'b0;
endmodule : lcsd_local_dev

// >>> tb/lcsd_decoder_chk.sv
// Port checker for the local chip select decoder.
`timescale 1ns/1ps
module lcsd_decoder_chk (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // APB slave
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [7:0] paddr,
    // Local bus cycle
    input wire logic       local_addr_strobe,
    input wire logic       local_cycle_active,
    input wire logic       local_space_claimed,
    // Selects and pin enables
    input wire logic       device_select0_n,
    input wire logic       device_select1_n,
    input wire logic       user_io_two_oe,
    input wire logic       user_io_three_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_idle;
        !local_addr_strobe && !local_cycle_active;
    endsequence
    sequence s_unclaim;
        local_addr_strobe && !local_space_claimed;
    endsequence
    a_idle_high: assert property (s_idle |=> device_select0_n && device_select1_n)
        else $error("select low outside a cycle");
    a_unclaim_high: assert property (s_unclaim |=> device_select0_n && device_select1_n)
        else $error("select low for unclaimed address");
    a_hold_sel: assert property (!local_addr_strobe && local_cycle_active |=> $stable(device_select0_n))
        else $error("select moved inside a cycle");
    a_fall_cause: assert property ($fell(device_select1_n) |-> $past(local_addr_strobe && local_space_claimed))
        else $error("select fell without claimed strobe");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_map_ok: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    a_unmap_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr && pready)
        else $error("no error on unmapped address");
    a_pin_cfg: assert property ($changed(user_io_two_oe) || $changed(user_io_three_oe) |-> $past(psel && penable && pwrite && paddr == 8'h10, 2))
        else $error("pin enable moved without write");
endmodule : lcsd_decoder_chk
bind lcsd_decoder lcsd_decoder_chk u_chk (.*);

// >>> tb/lcsd_decoder_tb_top.sv
// Self-checking testbench for the local chip select decoder.
`timescale 1ns/1ps
module lcsd_decoder_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lstb = 0, lact = 0, lclm = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [27:0] laddr = 28'h0;
    logic pready, pslverr, e, s0, s1, o2, oe2, o3, oe3, i2, i3;
    int mismatches = 0, comparisons = 0;
    localparam logic [27:0] TA [0:7] = '{28'h0024000, 28'h0027FFF, 28'h0023FFF, 28'h0028000,
                                        28'h0024000, 28'h0000003, 28'h0000004, 28'h0002000};
    localparam logic [3:0] TE [0:7] = '{4'hE, 4'hE, 4'hF, 4'hF, 4'hF, 4'h3, 4'hB, 4'hF};
    localparam logic [7:0] TC = 8'hEF;
    always #20 pclk = ~pclk;
    lcsd_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_addr(laddr), .local_addr_strobe(lstb), .local_cycle_active(lact),
        .local_space_claimed(lclm), .device_select0_n(s0), .device_select1_n(s1),
        .user_io_two_i(i2), .user_io_two_o(o2), .user_io_two_oe(oe2),
        .user_io_three_i(i3), .user_io_three_o(o3), .user_io_three_oe(oe3));
    lcsd_local_dev u_dev (.two_o(o2), .two_oe(oe2), .three_o(o3), .three_oe(oe3),
        .two_i(i2), .three_i(i3));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task close_out;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task lcyc(input logic [27:0] a, input logic c, input logic [3:0] x);
        @(posedge pclk);
        laddr <= a;
        lstb <= 1;
        lact <= 1;
        lclm <= c;
        @(posedge pclk);
        lstb <= 0;
        @(negedge pclk);
        chk({28'h0, o3, o2, s1, s0}, {28'h0, x});
        @(posedge pclk);
        lact <= 0;
        @(negedge pclk);
        chk({28'h0, o3, o2, s1, s0}, {28'h0, x});
        @(posedge pclk);
        @(negedge pclk);
        chk({28'h0, o3, o2, s1, s0}, 32'hF);
    endtask : lcyc
    task t_reset;
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 8'(4 * i), 32'h0);
            chk(r, 32'h0);
        end
        apb(0, 8'h10, 32'h0);
        chk({r[29:0], oe3, oe2}, 32'h0);
    endtask : t_reset
    task t_width;
        apb(1, 8'h00, 32'hFFFFFFFF);
        apb(0, 8'h00, 32'h0);
        chk(r, 32'h0FFFFFFF);
        apb(0, 8'h20, 32'h0);
        chk({r[30:0], e}, 32'h1);
    endtask : t_width
    task t_window;
        // Windows keep one range bit and a base aligned to it.
        apb(1, 8'h10, 32'h3);
        apb(1, 8'h00, 32'h0026001);
        apb(1, 8'h04, 32'h0026000);
        apb(1, 8'h08, 32'h0001001);
        apb(1, 8'h0C, 32'h0000003);
        chk({30'h0, oe3, oe2}, 32'h3);
        for (int i = 0; i < 8; i++)
            lcyc(TA[i], TC[i], TE[i]);
        apb(1, 8'h04, 32'h0026001);
        lcyc(28'h0025000, 1, 4'hC);
    endtask : t_window
    task t_pins;
        apb(1, 8'h10, 32'h14);
        // The pin flops pick up the control register one edge after the write.
        @(posedge pclk);
        @(negedge pclk);
        chk({29'h0, oe3, oe2, o2}, 32'h3);
        apb(0, 8'h14, 32'h0);
        chk({30'h0, r[5:4]}, 32'h1);
        apb(1, 8'h10, 32'h0);
        @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, oe3, oe2}, 32'h0);
    endtask : t_pins
    initial
    begin
        #400000;
        mismatches++;
        close_out;
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_width;
        t_window;
        t_pins;
        close_out;
    end
endmodule : lcsd_decoder_tb_top
